// *** hdl/ala_defs.svh ***
// Constants for the latched alarm block: bit positions, offsets, resets.
// Assumes inclusion by bare name from package and design files.
`ifndef ALA_DEFS_SVH
`define ALA_DEFS_SVH

`define ALA_WIDTH          16
`define ALA_BIT_POR        0
`define ALA_BIT_CDTOG      1
`define ALA_BIT_INIT       2
`define ALA_BIT_TIMER      3
`define ALA_BIT_SLEEP      4
`define ALA_BIT_WAKE       5
`define ALA_BIT_VSCAN      6
`define ALA_BIT_FSCAN      7
`define ALA_BIT_BAL        8
`define ALA_BIT_UVSHUT     9
`define ALA_BIT_DISCHOFF   10
`define ALA_BIT_CHARGEOFF  11
`define ALA_BIT_WARNB      12
`define ALA_BIT_WARNA      13
`define ALA_BIT_FAULTB     14
`define ALA_BIT_FAULTA     15

`define ALA_ADDR_W         4
`define ALA_OFS_LATCHED    4'h0
`define ALA_OFS_RAW        4'h1
`define ALA_OFS_ENABLE     4'h2
`define ALA_OFS_PINSTAT    4'h3

`define ALA_RST_FLAGS      16'h0000
`define ALA_RST_ENABLE     16'hffff
`define ALA_RST_ZERO16     16'h0000

`endif

// *** hdl/ala_pkg.sv ***
// Types shared by the latched alarm block.
// Assumes ala_defs.svh is on the include path.
`include "ala_defs.svh"

package ala_pkg;

    // Event sources as levels or pulses, 17 for the 16 status bits; both undervoltage sources share bit 9
    typedef struct packed {
        logic faultA;
        logic faultB;
        logic warnA;
        logic warnB;
        logic chargeDriverOn;
        logic dischDriverOn;
        logic cellUnderShut;
        logic stackUnderShut;
        logic balancing;
        logic fullScanDone;
        logic voltScanDone;
        logic wakePulse;
        logic sleepPulse;
        logic timerPulse;
        logic startupDone;
        logic chargerDetDebounced;
        logic porFlag;
    } ala_events_t;

    // Simple register port
    typedef struct packed {
        logic [`ALA_ADDR_W-1:0] addr;
        logic [`ALA_WIDTH-1:0]  wdata;
        logic                   wr;
        logic                   rd;
    } ala_bus_t;

endpackage

// *** hdl/ala_flag_bit.sv ***
// One latched alarm flag with set-over-clear priority.
// Assumes set and clear are synchronous single-cycle terms.
`timescale 1ns/1ps
`default_nettype none

module ala_flag_bit (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Control
    input  wire logic setEv,
    input  wire logic clearEv,
    // State
    output var  logic flag_reg
);

    logic flag_next;

    // Set wins so an event in the clearing cycle is kept
    assign flag_next = setEv | (flag_reg & ~clearEv); // see R22

    // Flag storage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

endmodule

`default_nettype wire

// *** hdl/ala_alarm_latch.sv ***
// Latched alarm status with enable mask and open-drain alert output.
// Assumes event inputs synchronous to clk_sys; host uses simple port.
`timescale 1ns/1ps
`default_nettype none
`include "ala_defs.svh"

//
// Contract
// R1 - Latch bit 14 on second fault word set
// R2 - Latch bit 13 on first warning word set
// R3 - Latch bit 12 on second warning word set
// R4 - Latch bit 11 when charge driver disables
// R5 - Latch bit 10 when discharge driver disables
// R6 - Latch bit 9 on cell/stack undervoltage shutdown
// R7 - Latch bit 8 while balancing is active
// R8 - Latch bit 7 on full scan done
// R9 - Latch bit 6 on voltage scan done
// R10 - Latch bit 5 on wake from sleep
// R11 - Latch bit 4 on sleep entry
// R12 - Latch bit 3 on timer expiry
// R13 - Latch bit 2 on startup sequence done
// R14 - Latch bit 1 on debounced detector change
// R15 - Latch bit 0 on full reset indication
// R16 - Writing one clears the flag
// R17 - Alert low while any flag set
// R18 - Latch bit 15 on first fault word
// R19 - Enable mask gates each raw bit
// R20 - Alert released, never driven high
// R21 - Release when clear; zero writes ignored
// R22 - Set beats simultaneous clear
module ala_alarm_latch (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // Event sources
    input  wire ala_pkg::ala_events_t   events,
    // Register port
    input  wire ala_pkg::ala_bus_t      bus,
    output var  logic [`ALA_WIDTH-1:0]  rdata_reg,
    // Alert pin, open drain
    output var  logic                   alertOut_reg,
    output var  logic                   alertOe_reg
);

    localparam int W = `ALA_WIDTH;

    ////////////////////////////////////////////////////////////////////
    // Edge memory for level sources

    logic          chargeOnDly_reg;
    logic          dischOnDly_reg;
    logic          chargerDetDly_reg;
    logic [W-1:0]  rawLevelDly_reg;
    logic [W-1:0]  enable_reg;
    logic [W-1:0]  flags;
    logic [W-1:0]  raw;
    logic [W-1:0]  rising;
    logic [W-1:0]  setVec;
    logic [W-1:0]  clrVec;
    logic [W-1:0]  keepVec;
    logic          anyFlag;

    // Raw word: levels for status sources, pulses for scan/timer events
    assign raw[`ALA_BIT_FAULTA] = events.faultA;
    assign raw[`ALA_BIT_FAULTB] = events.faultB;
    assign raw[`ALA_BIT_WARNA]  = events.warnA;
    assign raw[`ALA_BIT_WARNB]  = events.warnB;
    assign raw[`ALA_BIT_CHARGEOFF] = ~events.chargeDriverOn;
    assign raw[`ALA_BIT_DISCHOFF]  = ~events.dischDriverOn;
    assign raw[`ALA_BIT_UVSHUT]    = events.cellUnderShut | events.stackUnderShut; // see R6
    assign raw[`ALA_BIT_BAL]    = events.balancing;
    assign raw[`ALA_BIT_FSCAN]  = events.fullScanDone;
    assign raw[`ALA_BIT_VSCAN]  = events.voltScanDone;
    assign raw[`ALA_BIT_WAKE]   = events.wakePulse;
    assign raw[`ALA_BIT_SLEEP]  = events.sleepPulse;
    assign raw[`ALA_BIT_TIMER]  = events.timerPulse;
    assign raw[`ALA_BIT_INIT]   = events.startupDone;
    assign raw[`ALA_BIT_CDTOG]  = events.chargerDetDebounced ^ chargerDetDly_reg; // see R14
    assign raw[`ALA_BIT_POR]    = events.porFlag;

    // Fault and warning words latch on becoming set; a steady level
    // would otherwise refill the flag every cycle after the host clears it
    assign rising[`ALA_BIT_FAULTA] = raw[`ALA_BIT_FAULTA] & ~rawLevelDly_reg[`ALA_BIT_FAULTA];
    assign rising[`ALA_BIT_FAULTB] = raw[`ALA_BIT_FAULTB] & ~rawLevelDly_reg[`ALA_BIT_FAULTB];
    assign rising[`ALA_BIT_WARNA]  = raw[`ALA_BIT_WARNA] & ~rawLevelDly_reg[`ALA_BIT_WARNA];
    assign rising[`ALA_BIT_WARNB]  = raw[`ALA_BIT_WARNB] & ~rawLevelDly_reg[`ALA_BIT_WARNB];
    assign rising[`ALA_BIT_CHARGEOFF] = ~events.chargeDriverOn & chargeOnDly_reg;
    assign rising[`ALA_BIT_DISCHOFF]  = ~events.dischDriverOn & dischOnDly_reg;
    assign rising[`ALA_BIT_UVSHUT]    = raw[`ALA_BIT_UVSHUT];
    assign rising[`ALA_BIT_BAL]    = raw[`ALA_BIT_BAL];
    assign rising[`ALA_BIT_FSCAN]  = raw[`ALA_BIT_FSCAN];
    assign rising[`ALA_BIT_VSCAN]  = raw[`ALA_BIT_VSCAN];
    assign rising[`ALA_BIT_WAKE]   = raw[`ALA_BIT_WAKE];
    assign rising[`ALA_BIT_SLEEP]  = raw[`ALA_BIT_SLEEP];
    assign rising[`ALA_BIT_TIMER]  = raw[`ALA_BIT_TIMER];
    assign rising[`ALA_BIT_INIT]   = raw[`ALA_BIT_INIT];
    assign rising[`ALA_BIT_CDTOG]  = raw[`ALA_BIT_CDTOG];
    assign rising[`ALA_BIT_POR]    = raw[`ALA_BIT_POR];

    // Mask gates every source into the latched word
    assign setVec = rising & enable_reg; // see R1 R2 R3 R4 R5 R7 R18 R19

    // History of level sources
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chargeOnDly_reg   <= 1'b1;
            dischOnDly_reg    <= 1'b1;
            chargerDetDly_reg <= 1'b0;
            rawLevelDly_reg   <= `ALA_RST_ZERO16;
        end else begin
            chargeOnDly_reg   <= events.chargeDriverOn;
            dischOnDly_reg    <= events.dischDriverOn;
            chargerDetDly_reg <= events.chargerDetDebounced;
            rawLevelDly_reg   <= raw;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register port decode

    wire wrLatched = bus.wr && (bus.addr == `ALA_OFS_LATCHED);
    wire wrEnable  = bus.wr && (bus.addr == `ALA_OFS_ENABLE);

    // Only ones clear; zeros leave flags alone
    assign clrVec = wrLatched ? bus.wdata : `ALA_RST_ZERO16; // see R16 R21

    // Flags that no write clears this cycle, for the hold check
    assign keepVec = flags & ~clrVec;

    // Read mux; unmapped offsets read zero
    logic [W-1:0] rdata_next;
    assign rdata_next =
        !bus.rd                          ? `ALA_RST_ZERO16 :
        (bus.addr == `ALA_OFS_LATCHED)   ? flags :
        (bus.addr == `ALA_OFS_RAW)       ? raw :
        (bus.addr == `ALA_OFS_ENABLE)    ? enable_reg :
        (bus.addr == `ALA_OFS_PINSTAT)   ? {{(W-1){1'b0}}, alertOe_reg} :
                                           `ALA_RST_ZERO16;

    // Mask and read data registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enable_reg <= `ALA_RST_ENABLE;
            rdata_reg  <= `ALA_RST_ZERO16;
        end else begin
            if (wrEnable) begin
                enable_reg <= bus.wdata;
            end
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Latched flags

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : gFlag
            ala_flag_bit uFlag (
                .clk_sys (clk_sys),
                .rst     (rst),
                .setEv   (setVec[gi]), // see R8 R9 R10 R11 R12 R13 R15
                .clearEv (clrVec[gi]),
                .flag_reg(flags[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Alert pin: only pulls low, otherwise released

    assign anyFlag = |flags;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alertOut_reg <= 1'b0;
            alertOe_reg  <= 1'b0;
        end else begin
            alertOut_reg <= 1'b0;      // see R20
            alertOe_reg  <= anyFlag;   // see R17 R21
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    alert_follows_a: assert property (@(posedge clk_sys) disable iff (rst) // see R17
        anyFlag |=> alertOe_reg)
        else $error("alert not asserted with flag set");

    alert_release_a: assert property (@(posedge clk_sys) disable iff (rst) // see R21
        !anyFlag |=> !alertOe_reg)
        else $error("alert held with no flag");

    never_high_a: assert property (@(posedge clk_sys) disable iff (rst) // see R20
        alertOe_reg |-> !alertOut_reg)
        else $error("alert driven high");

    set_wins_a: assert property (@(posedge clk_sys) disable iff (rst) // see R22
        (setVec[`ALA_BIT_BAL] && clrVec[`ALA_BIT_BAL]) |=> flags[`ALA_BIT_BAL])
        else $error("event lost on clear");

    w1c_clear_a: assert property (@(posedge clk_sys) disable iff (rst) // see R16
        (wrLatched && bus.wdata[`ALA_BIT_TIMER] && !setVec[`ALA_BIT_TIMER])
        |=> !flags[`ALA_BIT_TIMER])
        else $error("write one failed to clear");

    zero_keeps_a: assert property (@(posedge clk_sys) disable iff (rst) // see R21
        (flags[`ALA_BIT_INIT] && !clrVec[`ALA_BIT_INIT]) |=> flags[`ALA_BIT_INIT])
        else $error("flag lost without clear");

    mask_gates_a: assert property (@(posedge clk_sys) disable iff (rst) // see R19
        (!flags[`ALA_BIT_WAKE] && !enable_reg[`ALA_BIT_WAKE]) |=> !flags[`ALA_BIT_WAKE])
        else $error("masked source latched");

    charge_off_a: assert property (@(posedge clk_sys) disable iff (rst) // see R4
        ($fell(events.chargeDriverOn) && enable_reg[`ALA_BIT_CHARGEOFF])
        |=> flags[`ALA_BIT_CHARGEOFF])
        else $error("charge off not latched");

    toggle_a: assert property (@(posedge clk_sys) disable iff (rst) // see R14
        ($changed(events.chargerDetDebounced) && enable_reg[`ALA_BIT_CDTOG])
        |=> flags[`ALA_BIT_CDTOG])
        else $error("detector change not latched");

    undervolt_alert_a: assert property (@(posedge clk_sys) disable iff (rst) // see R6
        (events.stackUnderShut && enable_reg[`ALA_BIT_UVSHUT]) |=> ##1 alertOe_reg)
        else $error("undervoltage did not alert");

    // Per-source latching, one check for each bit of the word except 11 and 1
    fault_a_latch_a: assert property (@(posedge clk_sys) disable iff (rst) // see R18
        ($rose(events.faultA) && enable_reg[`ALA_BIT_FAULTA])
        |=> flags[`ALA_BIT_FAULTA])
        else $error("first fault word not latched");

    fault_b_latch_a: assert property (@(posedge clk_sys) disable iff (rst) // see R1
        ($rose(events.faultB) && enable_reg[`ALA_BIT_FAULTB])
        |=> flags[`ALA_BIT_FAULTB])
        else $error("second fault word not latched");

    warn_a_latch_a: assert property (@(posedge clk_sys) disable iff (rst) // see R2
        ($rose(events.warnA) && enable_reg[`ALA_BIT_WARNA])
        |=> flags[`ALA_BIT_WARNA])
        else $error("first warning word not latched");

    warn_b_latch_a: assert property (@(posedge clk_sys) disable iff (rst) // see R3
        ($rose(events.warnB) && enable_reg[`ALA_BIT_WARNB])
        |=> flags[`ALA_BIT_WARNB])
        else $error("second warning word not latched");

    disch_off_a: assert property (@(posedge clk_sys) disable iff (rst) // see R5
        ($fell(events.dischDriverOn) && enable_reg[`ALA_BIT_DISCHOFF])
        |=> flags[`ALA_BIT_DISCHOFF])
        else $error("discharge off not latched");

    cell_under_a: assert property (@(posedge clk_sys) disable iff (rst) // see R6
        (events.cellUnderShut && enable_reg[`ALA_BIT_UVSHUT])
        |=> flags[`ALA_BIT_UVSHUT])
        else $error("cell undervoltage not latched");

    balance_latch_a: assert property (@(posedge clk_sys) disable iff (rst) // see R7
        (events.balancing && enable_reg[`ALA_BIT_BAL])
        |=> flags[`ALA_BIT_BAL])
        else $error("balancing not latched");

    full_scan_a: assert property (@(posedge clk_sys) disable iff (rst) // see R8
        (events.fullScanDone && enable_reg[`ALA_BIT_FSCAN])
        |=> flags[`ALA_BIT_FSCAN])
        else $error("full scan not latched");

    volt_scan_a: assert property (@(posedge clk_sys) disable iff (rst) // see R9
        (events.voltScanDone && enable_reg[`ALA_BIT_VSCAN])
        |=> flags[`ALA_BIT_VSCAN])
        else $error("voltage scan not latched");

    wake_latch_a: assert property (@(posedge clk_sys) disable iff (rst) // see R10
        (events.wakePulse && enable_reg[`ALA_BIT_WAKE])
        |=> flags[`ALA_BIT_WAKE])
        else $error("wake not latched");

    sleep_latch_a: assert property (@(posedge clk_sys) disable iff (rst) // see R11
        (events.sleepPulse && enable_reg[`ALA_BIT_SLEEP])
        |=> flags[`ALA_BIT_SLEEP])
        else $error("sleep entry not latched");

    timer_latch_a: assert property (@(posedge clk_sys) disable iff (rst) // see R12
        (events.timerPulse && enable_reg[`ALA_BIT_TIMER])
        |=> flags[`ALA_BIT_TIMER])
        else $error("timer expiry not latched");

    startup_latch_a: assert property (@(posedge clk_sys) disable iff (rst) // see R13
        (events.startupDone && enable_reg[`ALA_BIT_INIT])
        |=> flags[`ALA_BIT_INIT])
        else $error("startup done not latched");

    reset_ind_a: assert property (@(posedge clk_sys) disable iff (rst) // see R15
        (events.porFlag && enable_reg[`ALA_BIT_POR])
        |=> flags[`ALA_BIT_POR])
        else $error("reset indication not latched");

    // Whole-word clear and hold, beyond the single-bit checks above
    clear_all_a: assert property (@(posedge clk_sys) disable iff (rst) // see R16
        (wrLatched && ((bus.wdata & setVec) == `ALA_RST_ZERO16))
        |=> ((flags & $past(bus.wdata)) == `ALA_RST_ZERO16))
        else $error("written ones left flags set");

    keep_all_a: assert property (@(posedge clk_sys) disable iff (rst) // see R21
        (keepVec != `ALA_RST_ZERO16)
        |=> ((flags & $past(keepVec)) == $past(keepVec)))
        else $error("flag dropped without a clear");

endmodule

`default_nettype wire

// *** test/ala_host_pin.sv ***
// Host side of the open-drain alert pin: pull-up and wire resolution.
// Assumes the alert enable is high while the device pulls the pin.
`timescale 1ns/1ps
`default_nettype none

module ala_host_pin (
    // Device drive
    input  wire logic alertOut,
    input  wire logic alertOe,
    // Level seen by the host
    output wire logic alertPin
);
    // Pull-up wins once released, so a stale low never shows
    assign alertPin = alertOe ? alertOut : 1'b1;
endmodule

`default_nettype wire

// *** test/alarm_latch_alert_bench.sv ***
// Testbench for the latched alarm block: register tasks and alarm tests.
// Assumes design files and the host pin model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "ala_defs.svh"

module alarm_latch_alert_bench;
    localparam logic [16:0] EV_IDLE = 17'h01800; // Both drivers on
    logic                   clk_sys;
    logic                   rst;
    ala_pkg::ala_events_t   events;
    ala_pkg::ala_bus_t      bus;
    logic [`ALA_WIDTH-1:0]  rdata;
    logic                   alertOut;
    logic                   alertOe;
    logic                   alertPin;
    logic [`ALA_WIDTH-1:0]  got;
    logic [`ALA_WIDTH-1:0]  oneHot;
    int                     failures;
    int                     nCompared;

    ala_alarm_latch i_dut (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .events       (events),
        .bus          (bus),
        .rdata_reg    (rdata),
        .alertOut_reg (alertOut),
        .alertOe_reg  (alertOe)
    );

    ala_host_pin i_host (
        .alertOut (alertOut),
        .alertOe  (alertOe),
        .alertPin (alertPin)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus and event tasks
    task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic regRead(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus <= '0;
        #1;
        d = rdata;
    endtask

    task automatic check(input logic [15:0] g, input logic [15:0] e);
        nCompared++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // One-cycle deviation from idle; drivers drop, others rise
    task automatic pulse(input int k);
        @(posedge clk_sys);
        events <= EV_IDLE ^ (17'h00001 << k);
        @(posedge clk_sys);
        events <= EV_IDLE;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        failures = 0;
        nCompared = 0;
        rst = 1'b1;
        events = EV_IDLE;
        bus = '0;
        tick(10);
        rst <= 1'b0;
        regRead(`ALA_OFS_LATCHED, got);
        check(got, `ALA_RST_FLAGS);
        regRead(`ALA_OFS_ENABLE, got);
        check(got, `ALA_RST_ENABLE);
        check({15'h0000, alertPin}, 16'h0001);
        $display("test reset done");
        // Every status bit latches from one source (cell undervoltage for bit 9), raises alert, clears on one
        for (int b = 0; b < 16; b++) begin
            oneHot = 16'h0001 << b;
            pulse((b >= 9) ? b + 1 : b);
            tick(3);
            regRead(`ALA_OFS_LATCHED, got);
            check(got, oneHot);
            check({15'h0000, alertPin}, 16'h0000);
            regWrite(`ALA_OFS_LATCHED, oneHot);
            tick(3);
            regRead(`ALA_OFS_LATCHED, got);
            check(got, 16'h0000);
            check({15'h0000, alertPin}, 16'h0001);
        end
        $display("test sources done");
        // Masked sources never latch nor alert
        regWrite(`ALA_OFS_ENABLE, 16'h0000);
        for (int k = 0; k < 17; k++) pulse(k);
        tick(3);
        regRead(`ALA_OFS_LATCHED, got);
        check(got, 16'h0000);
        check({15'h0000, alertPin}, 16'h0001);
        regWrite(`ALA_OFS_ENABLE, 16'hffff);
        pulse(9);
        tick(3);
        regRead(`ALA_OFS_LATCHED, got);
        check(got, 16'h0200);
        regWrite(`ALA_OFS_LATCHED, 16'h0200);
        $display("test mask done");
        // Zero write keeps flags; set wins over a same-cycle clear
        pulse(3);
        tick(3);
        regWrite(`ALA_OFS_LATCHED, 16'h0000);
        regRead(`ALA_OFS_LATCHED, got);
        check(got, 16'h0008);
        @(posedge clk_sys);
        events <= EV_IDLE | 17'h00100;
        regWrite(`ALA_OFS_LATCHED, 16'h0108);
        regRead(`ALA_OFS_LATCHED, got);
        check(got, 16'h0100);
        regRead(`ALA_OFS_RAW, got);
        check(got, 16'h0100);
        regRead(`ALA_OFS_PINSTAT, got);
        check(got, 16'h0001);
        @(posedge clk_sys);
        events <= EV_IDLE;
        tick(2);
        regWrite(`ALA_OFS_LATCHED, 16'h0100);
        tick(3);
        regRead(`ALA_OFS_LATCHED, got);
        check(got, 16'h0000);
        check({15'h0000, alertPin}, 16'h0001);
        regRead(4'h7, got);
        check(got, 16'h0000);
        $display("test clear done");
        end_of_test();
    end
endmodule

`default_nettype wire
